// ==== i2c_engine_cfg.svh ====
`ifndef I2C_ENGINE_CFG_SVH
`define I2C_ENGINE_CFG_SVH

// Internal register addresses
`define REG_CLKDIV_ADDR   8'h02
`define REG_TIMEOUT_ADDR  8'h03
`define REG_STATUS_ADDR   8'h04
`define REG_OWNADDR_ADDR  8'h05
`define REG_XTO_ADDR      8'h09

// Reset values
`define CLKDIV_RESET      8'ha0
`define TIMEOUT_RESET     8'h00
`define OWNADDR_RESET     8'h00
`define XTO_RESET         8'h00
`define STATUS_RESET      8'h00

// Field positions
`define TO_EN_BIT         0
`define TO_VAL_MSB        7
`define TO_VAL_LSB        1
`define XTO_LOW_BIT       0
`define XTO_FREE_BIT      1

// Transaction result codes
`define ST_OK             8'hf0
`define ST_ADDR_NACK      8'hf1
`define ST_DATA_NACK      8'hf2
`define ST_BUSY           8'hf3
`define ST_TIMEOUT        8'hf8
`define ST_SCL_LOW        8'hfa
`define ST_NOT_FREE       8'hfb

// Timing
`define CLK_PERIOD_NS     20
`define SCL_MAX_KHZ       400
`define SCL_DIV_KHZ       2000
`define SCL_DIV_MIN       ((`SCL_DIV_KHZ + `SCL_MAX_KHZ - 1) / `SCL_MAX_KHZ)
`define SCL_UNIT_NS       (1000000 / `SCL_DIV_KHZ)
`define SCL_UNIT_CYC      (`SCL_UNIT_NS / `CLK_PERIOD_NS)
`define TO_TICK_NS        7812500
`define TO_TICK_CYC       (`TO_TICK_NS / `CLK_PERIOD_NS)
`define TO_ACC_LIMIT      16'h4000
`define SCL_LOW_TO_MS     25
`define SCL_LOW_TO_CYC    (`SCL_LOW_TO_MS * 1000000 / `CLK_PERIOD_NS)
`define BUS_FREE_US       50
`define BUS_FREE_CYC      ((`BUS_FREE_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Transmit buffer
`define FIFO_WIDTH        8
`define FIFO_DEPTH        32

`endif

// ==== i2c_engine_pkg.sv ====
package i2c_engine_pkg;

	typedef enum logic [2:0] {
		M_IDLE  = 3'h0,
		M_FREE  = 3'h1,
		M_START = 3'h2,
		M_XFER  = 3'h3,
		M_STOP  = 3'h4,
		M_DONE  = 3'h5
	} master_state_t;

	typedef enum logic [1:0] {
		S_IDLE   = 2'h0,
		S_ADDR   = 2'h1,
		S_ACK    = 2'h2,
		S_IGNORE = 2'h3
	} slave_state_t;

endpackage

// ==== sync_fifo.sv ====
`timescale 1ns/1ps
module sync_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input  wire logic             clock_i,
	input  wire logic             resetn_i,
	// Fill side
	input  wire logic [WIDTH-1:0] in_data_i,
	input  wire logic             in_valid_i,
	output      logic             in_ready_o,
	// Drain side
	output      logic [WIDTH-1:0] out_data_o,
	output      logic             out_valid_o,
	input  wire logic             out_ready_i
);
	localparam int              AW   = $clog2(DEPTH);
	localparam logic [AW:0]     FULL = DEPTH[AW:0];

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    next_wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW-1:0]    next_rd_ptr;
	logic [AW:0]      count;
	logic [AW:0]      next_count;
	logic [WIDTH-1:0] next_out_data;
	logic             next_out_valid;
	logic             push;
	logic             pop;

	assign in_ready_o = (count != FULL);

	always_comb begin
		push           = in_valid_i && in_ready_o;
		pop            = (count != '0) && (!out_valid_o || out_ready_i);
		next_wr_ptr    = push ? wr_ptr + 1'b1 : wr_ptr;
		next_rd_ptr    = pop ? rd_ptr + 1'b1 : rd_ptr;
		next_count     = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		next_out_data  = pop ? mem[rd_ptr] : out_data_o;
		next_out_valid = pop || (out_valid_o && !out_ready_i);
	end

	always_ff @(posedge clock_i) begin
		if (push) begin
			mem[wr_ptr] <= in_data_i;
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wr_ptr      <= '0;
			rd_ptr      <= '0;
			count       <= '0;
			out_data_o  <= '0;
			out_valid_o <= 1'b0;
		end else begin
			wr_ptr      <= next_wr_ptr;
			rd_ptr      <= next_rd_ptr;
			count       <= next_count;
			out_data_o  <= next_out_data;
			out_valid_o <= next_out_valid;
		end
	end
endmodule // sync_fifo

// ==== i2c_master_engine.sv ====
`timescale 1ns/1ps
`include "i2c_engine_cfg.svh"
module i2c_master_engine #(
	parameter int TO_TICK_CYC_P  = `TO_TICK_CYC,
	parameter int SCL_LOW_CYC_P  = `SCL_LOW_TO_CYC,
	parameter int BUS_FREE_CYC_P = `BUS_FREE_CYC
) (
	// Clock and reset
	input  wire logic       clock_i,
	input  wire logic       resetn_i,
	// Internal register port
	input  wire logic [7:0] reg_addr_i,
	input  wire logic       reg_wr_i,
	input  wire logic [7:0] reg_wdata_i,
	input  wire logic       reg_rd_i,
	output      logic [7:0] reg_rdata_o,
	// Command port
	input  wire logic       spi_active_i,
	input  wire logic       cmd_valid_i,
	input  wire logic       cmd_read_i,
	input  wire logic [6:0] cmd_slave_i,
	input  wire logic [7:0] cmd_count_i,
	output      logic       cmd_taken_o,
	// Transmit data
	input  wire logic [7:0] tx_data_i,
	input  wire logic       tx_valid_i,
	output      logic       tx_ready_o,
	// Receive data
	output      logic [7:0] rx_data_o,
	output      logic       rx_valid_o,
	// Completion interrupt
	input  wire logic       int_clear_i,
	output      logic       int_n_o,
	// Bus pins
	input  wire logic       scl_i,
	output      logic       scl_o,
	output      logic       scl_oe_n_o,
	input  wire logic       sda_i,
	output      logic       sda_o,
	output      logic       sda_oe_n_o
);
	i2c_engine_pkg::master_state_t m_state, next_m_state;
	i2c_engine_pkg::slave_state_t  s_state, next_s_state;

	logic [7:0]  clk_div, next_clk_div, to_reg, next_to_reg, own_addr, next_own_addr;
	logic [7:0]  xto_reg, next_xto_reg, status, next_status, next_rdata, next_rx_data;
	logic        int_pending, next_int, next_rx_valid;
	logic [11:0] act_quarter, next_quarter, qcnt, next_qcnt;
	logic        act_to_en, next_to_en, act_free, next_free, act_low, next_low;
	logic [6:0]  act_to_val, next_to_val, cmd_slave, next_cmd_slave;
	logic        cmd_rd, next_cmd_rd, first_byte, next_first, retry, next_retry;
	logic [7:0]  bytes_left, next_left, remaining, shreg, next_shreg;
	logic [1:0]  phase, next_phase;
	logic [3:0]  bit_cnt, next_bit_cnt, s_cnt, next_s_cnt;
	logic        scl_drv, next_scl_drv, sda_drv, next_sda_drv, s_sda_drv, next_s_sda_drv;
	logic [23:0] presc, next_presc, low_cnt, next_low_cnt;
	logic [15:0] to_acc, next_to_acc;
	logic [11:0] free_cnt, next_free_cnt;
	logic [7:0]  s_shreg, next_s_shreg;
	logic        scl_q, sda_q, busy, tick, tx, hold, timeout_hit, low_hit;
	logic [7:0]  fifo_data;
	logic        fifo_valid, fifo_pop;

	function automatic logic bus_idle(input logic scl, input logic sda);
		bus_idle = scl && sda;
	endfunction

	// Quarter of an SCL period in clocks, divider clamped to the fastest legal rate
	function automatic logic [11:0] quarter_of(input logic [7:0] div);
		logic [7:0]  eff;
		logic [12:0] prod;
		eff  = (div < 8'(`SCL_DIV_MIN)) ? 8'(`SCL_DIV_MIN) : div;
		prod = {5'h00, eff} * 13'(`SCL_UNIT_CYC);
		quarter_of = 12'(prod >> 2);
	endfunction

	sync_fifo #(
		.WIDTH (`FIFO_WIDTH),
		.DEPTH (`FIFO_DEPTH)
	) tx_fifo (
		.clock_i     (clock_i),
		.resetn_i    (resetn_i),
		.in_data_i   (tx_data_i),
		.in_valid_i  (tx_valid_i),
		.in_ready_o  (tx_ready_o),
		.out_data_o  (fifo_data),
		.out_valid_o (fifo_valid),
		.out_ready_i (fifo_pop)
	);

	assign busy        = (m_state != i2c_engine_pkg::M_IDLE) && (m_state != i2c_engine_pkg::M_DONE);
	assign cmd_taken_o = cmd_valid_i && (m_state == i2c_engine_pkg::M_IDLE);
	assign int_n_o     = !int_pending;
	assign scl_o       = 1'b0;
	assign sda_o       = 1'b0;
	assign scl_oe_n_o  = !scl_drv;
	assign sda_oe_n_o  = !(sda_drv || s_sda_drv);

	// Register file
	always_comb begin
		next_clk_div  = clk_div;
		next_to_reg   = to_reg;
		next_own_addr = own_addr;
		next_xto_reg  = xto_reg;
		next_rdata    = reg_rdata_o;
		if (reg_wr_i) begin
			case (reg_addr_i)
				`REG_CLKDIV_ADDR:  next_clk_div  = reg_wdata_i;
				`REG_TIMEOUT_ADDR: next_to_reg   = reg_wdata_i;
				`REG_OWNADDR_ADDR: next_own_addr = reg_wdata_i;
				`REG_XTO_ADDR:     next_xto_reg  = reg_wdata_i;
				default: ;
			endcase
		end
		if (reg_rd_i) begin
			case (reg_addr_i)
				`REG_CLKDIV_ADDR:  next_rdata = clk_div;
				`REG_TIMEOUT_ADDR: next_rdata = to_reg;
				`REG_STATUS_ADDR:  next_rdata = status;
				`REG_OWNADDR_ADDR: next_rdata = own_addr;
				`REG_XTO_ADDR:     next_rdata = xto_reg;
				default:           next_rdata = 8'h00;
			endcase
		end
	end

	// Master engine
	always_comb begin
		next_m_state   = m_state;
		next_phase     = phase;
		next_qcnt      = qcnt;
		next_bit_cnt   = bit_cnt;
		next_shreg     = shreg;
		next_scl_drv   = scl_drv;
		next_sda_drv   = sda_drv;
		next_first     = first_byte;
		next_left      = bytes_left;
		next_retry     = retry;
		next_status    = status;
		next_int       = int_pending && !int_clear_i;
		next_cmd_rd    = cmd_rd;
		next_cmd_slave = cmd_slave;
		next_quarter   = act_quarter;
		next_to_en     = act_to_en;
		next_to_val    = act_to_val;
		next_free      = act_free;
		next_low       = act_low;
		next_presc     = presc;
		next_to_acc    = to_acc;
		next_low_cnt   = low_cnt;
		next_free_cnt  = free_cnt;
		next_rx_data   = rx_data_o;
		next_rx_valid  = 1'b0;
		fifo_pop       = 1'b0;
		tick           = 1'b0;
		hold           = 1'b0;
		remaining      = bytes_left;
		tx             = first_byte || !cmd_rd;
		// Quarter-bit timebase; slave stretching holds the high phase
		if (busy && !spi_active_i) begin
			if (phase == 2'd3 && !scl_i) begin
				next_qcnt = '0;
			end else if (qcnt >= act_quarter - 12'h001) begin
				next_qcnt = '0;
				tick      = 1'b1;
			end else begin
				next_qcnt = qcnt + 12'h001;
			end
		end
		if (busy) begin
			if (presc >= 24'(TO_TICK_CYC_P - 1)) begin
				next_presc  = '0;
				next_to_acc = to_acc + {9'h000, act_to_val};
			end else begin
				next_presc = presc + 24'h000001;
			end
			next_low_cnt = scl_i ? '0 : low_cnt + 24'h000001;
		end
		timeout_hit = act_to_en && (to_acc >= `TO_ACC_LIMIT);
		low_hit     = act_low && (low_cnt >= 24'(SCL_LOW_CYC_P));
		if (busy && (timeout_hit || low_hit)) begin
			next_status  = timeout_hit ? `ST_TIMEOUT : `ST_SCL_LOW;
			next_scl_drv = 1'b0;
			next_sda_drv = 1'b0;
			next_retry   = 1'b0;
			next_m_state = i2c_engine_pkg::M_DONE;
		end else begin
			unique case (m_state)
				i2c_engine_pkg::M_IDLE: begin
					if (cmd_valid_i) begin
						next_cmd_rd    = cmd_read_i;
						next_cmd_slave = cmd_slave_i;
						next_left      = cmd_count_i;
						next_quarter   = quarter_of(clk_div);
						next_to_en     = to_reg[`TO_EN_BIT];
						next_to_val    = to_reg[`TO_VAL_MSB:`TO_VAL_LSB];
						next_free      = xto_reg[`XTO_FREE_BIT];
						next_low       = xto_reg[`XTO_LOW_BIT];
						next_presc     = '0;
						next_to_acc    = '0;
						next_low_cnt   = '0;
						next_retry     = 1'b0;
						next_status    = `ST_BUSY;
						next_free_cnt  = '0;
						next_m_state   = i2c_engine_pkg::M_FREE;
					end
				end
				i2c_engine_pkg::M_FREE: begin
					next_phase = 2'd0;
					next_qcnt  = '0;
					if (act_free) begin
						next_free_cnt = bus_idle(scl_i, sda_i) ? free_cnt + 12'h001 : '0;
						if (free_cnt >= 12'(BUS_FREE_CYC_P - 1) && bus_idle(scl_i, sda_i)) begin
							next_m_state = i2c_engine_pkg::M_START;
						end
					end else if (bus_idle(scl_i, sda_i)) begin
						next_m_state = i2c_engine_pkg::M_START;
					end else begin
						next_status  = `ST_NOT_FREE;
						next_m_state = i2c_engine_pkg::M_DONE;
					end
				end
				i2c_engine_pkg::M_START: begin
					if (tick) begin
						next_phase = phase + 2'd1;
						if (phase == 2'd1) begin
							next_sda_drv = 1'b1;
						end
						if (phase == 2'd3) begin
							next_scl_drv = 1'b1;
							next_shreg   = {cmd_slave, cmd_rd};
							next_bit_cnt = 4'h0;
							next_first   = 1'b1;
							next_m_state = i2c_engine_pkg::M_XFER;
						end
					end
				end
				i2c_engine_pkg::M_XFER: begin
					if (tick) begin
						unique case (phase)
							2'd0: next_sda_drv = (bit_cnt == 4'h8) ? (!tx && bytes_left != 8'h01)
							                                       : (tx && !shreg[7]);
							2'd1: ;
							2'd2: next_scl_drv = 1'b0;
							2'd3: begin
								next_scl_drv = 1'b1;
								if (bit_cnt != 4'h8) begin
									next_shreg   = {shreg[6:0], sda_i};
									next_bit_cnt = bit_cnt + 4'h1;
								end else if (tx && sda_i) begin
									next_bit_cnt = 4'h0;
									next_retry   = first_byte && act_to_en;
									if (!(first_byte && act_to_en)) begin
										next_status = first_byte ? `ST_ADDR_NACK : `ST_DATA_NACK;
									end
									next_m_state = i2c_engine_pkg::M_STOP;
								end else begin
									remaining = first_byte ? bytes_left : bytes_left - 8'h01;
									if (remaining != 8'h00 && !cmd_rd && !fifo_valid) begin
										hold         = 1'b1;
										next_scl_drv = 1'b0;
									end else begin
										next_bit_cnt = 4'h0;
										next_left    = remaining;
										next_first   = 1'b0;
										if (!tx) begin
											next_rx_data  = shreg;
											next_rx_valid = 1'b1;
										end
										if (remaining == 8'h00) begin
											next_status  = `ST_OK;
											next_m_state = i2c_engine_pkg::M_STOP;
										end else if (!cmd_rd) begin
											next_shreg = fifo_data;
											fifo_pop   = 1'b1;
										end
									end
								end
							end
						endcase
						next_phase = hold ? phase : phase + 2'd1;
					end
				end
				i2c_engine_pkg::M_STOP: begin
					if (tick) begin
						next_phase = phase + 2'd1;
						unique case (phase)
							2'd0: next_sda_drv = 1'b1;
							2'd1: ;
							2'd2: next_scl_drv = 1'b0;
							2'd3: begin
								next_sda_drv  = 1'b0;
								next_retry    = 1'b0;
								next_free_cnt = '0;
								next_m_state  = retry ? i2c_engine_pkg::M_FREE : i2c_engine_pkg::M_DONE;
							end
						endcase
					end
				end
				i2c_engine_pkg::M_DONE: begin
					next_int     = 1'b1;
					next_scl_drv = 1'b0;
					next_sda_drv = 1'b0;
					next_m_state = i2c_engine_pkg::M_IDLE;
				end
				default: next_m_state = i2c_engine_pkg::M_IDLE;
			endcase
		end
	end

	// Own-address slave responder
	always_comb begin
		next_s_state   = s_state;
		next_s_cnt     = s_cnt;
		next_s_shreg   = s_shreg;
		next_s_sda_drv = s_sda_drv;
		if (m_state != i2c_engine_pkg::M_IDLE) begin
			next_s_state   = i2c_engine_pkg::S_IDLE;
			next_s_sda_drv = 1'b0;
		end else if (scl_q && scl_i && sda_q && !sda_i) begin
			next_s_state   = i2c_engine_pkg::S_ADDR;
			next_s_cnt     = 4'h0;
			next_s_sda_drv = 1'b0;
		end else if (scl_q && scl_i && !sda_q && sda_i) begin
			next_s_state   = i2c_engine_pkg::S_IDLE;
			next_s_sda_drv = 1'b0;
		end else begin
			unique case (s_state)
				i2c_engine_pkg::S_IDLE: ;
				i2c_engine_pkg::S_ADDR: begin
					if (!scl_q && scl_i && s_cnt != 4'h8) begin
						next_s_shreg = {s_shreg[6:0], sda_i};
						next_s_cnt   = s_cnt + 4'h1;
					end else if (scl_q && !scl_i && s_cnt == 4'h8) begin
						if (own_addr != 8'h00 && own_addr[7:1] == s_shreg[7:1]
						    && !spi_active_i) begin
							next_s_sda_drv = 1'b1;
							next_s_state   = i2c_engine_pkg::S_ACK;
						end else begin
							next_s_state = i2c_engine_pkg::S_IGNORE;
						end
					end
				end
				i2c_engine_pkg::S_ACK: begin
					if (scl_q && !scl_i) begin
						next_s_sda_drv = 1'b0;
						next_s_state   = i2c_engine_pkg::S_IGNORE;
					end
				end
				i2c_engine_pkg::S_IGNORE: ;
			endcase
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			clk_div     <= `CLKDIV_RESET;
			to_reg      <= `TIMEOUT_RESET;
			own_addr    <= `OWNADDR_RESET;
			xto_reg     <= `XTO_RESET;
			reg_rdata_o <= 8'h00;
			m_state     <= i2c_engine_pkg::M_IDLE;
			phase       <= 2'd0;
			qcnt        <= '0;
			bit_cnt     <= 4'h0;
			shreg       <= 8'h00;
			scl_drv     <= 1'b0;
			sda_drv     <= 1'b0;
			first_byte  <= 1'b0;
			bytes_left  <= 8'h00;
			retry       <= 1'b0;
			status      <= `STATUS_RESET;
			int_pending <= 1'b0;
			cmd_rd      <= 1'b0;
			cmd_slave   <= 7'h00;
			act_quarter <= 12'h001;
			act_to_en   <= 1'b0;
			act_to_val  <= 7'h00;
			act_free    <= 1'b0;
			act_low     <= 1'b0;
			presc       <= '0;
			to_acc      <= '0;
			low_cnt     <= '0;
			free_cnt    <= '0;
			rx_data_o   <= 8'h00;
			rx_valid_o  <= 1'b0;
			s_state     <= i2c_engine_pkg::S_IDLE;
			s_cnt       <= 4'h0;
			s_shreg     <= 8'h00;
			s_sda_drv   <= 1'b0;
			scl_q       <= 1'b1;
			sda_q       <= 1'b1;
		end else begin
			clk_div     <= next_clk_div;
			to_reg      <= next_to_reg;
			own_addr    <= next_own_addr;
			xto_reg     <= next_xto_reg;
			reg_rdata_o <= next_rdata;
			m_state     <= next_m_state;
			phase       <= next_phase;
			qcnt        <= next_qcnt;
			bit_cnt     <= next_bit_cnt;
			shreg       <= next_shreg;
			scl_drv     <= next_scl_drv;
			sda_drv     <= next_sda_drv;
			first_byte  <= next_first;
			bytes_left  <= next_left;
			retry       <= next_retry;
			status      <= next_status;
			int_pending <= next_int;
			cmd_rd      <= next_cmd_rd;
			cmd_slave   <= next_cmd_slave;
			act_quarter <= next_quarter;
			act_to_en   <= next_to_en;
			act_to_val  <= next_to_val;
			act_free    <= next_free;
			act_low     <= next_low;
			presc       <= next_presc;
			to_acc      <= next_to_acc;
			low_cnt     <= next_low_cnt;
			free_cnt    <= next_free_cnt;
			rx_data_o   <= next_rx_data;
			rx_valid_o  <= next_rx_valid;
			s_state     <= next_s_state;
			s_cnt       <= next_s_cnt;
			s_shreg     <= next_s_shreg;
			s_sda_drv   <= next_s_sda_drv;
			scl_q       <= scl_i;
			sda_q       <= sda_i;
		end
	end
endmodule // i2c_master_engine

// ==== i2c_slave_model.sv ====
`timescale 1ns/1ps
module i2c_slave_model #(
	parameter logic [6:0] ADDR = 7'h50
) (
	// Clock and stretch request
	input  wire logic clock_i,
	input  wire logic hold_i,
	// Bus wires
	input  wire logic scl_i,
	input  wire logic sda_i,
	output      logic scl_oe_n_o,
	output      logic sda_oe_n_o
);
	logic       ps = 1'b1;
	logic       pd = 1'b1;
	logic       act = 1'b0;
	logic       adr = 1'b0;
	logic       rdm = 1'b0;
	logic [7:0] sh = 8'h00;
	logic [7:0] rdat = 8'ha5;
	logic [7:0] got[$];
	int         bitn = 0;

	// Stretching pulls SCL low for as long as the bench asks
	assign scl_oe_n_o = !hold_i;
	initial sda_oe_n_o = 1'b1;

	always @(posedge clock_i) begin
		ps <= scl_i;
		pd <= sda_i;
		if (ps && scl_i && pd != sda_i) begin
			// Start arms the frame, stop ends it
			act <= !sda_i;
			adr <= 1'b1;
			bitn <= 0;
			sda_oe_n_o <= 1'b1;
		end else if (act && !ps && scl_i) begin
			if (bitn < 8)
				sh <= {sh[6:0], sda_i};
			else if (rdm && !adr && sda_i)
				act <= 1'b0;
			bitn <= bitn + 1;
		end else if (act && ps && !scl_i) begin
			if (bitn == 8 && adr) begin
				act <= sh[7:1] == ADDR;
				rdm <= sh[0];
				sda_oe_n_o <= sh[7:1] != ADDR;
			end else if (bitn == 8) begin
				if (!rdm)
					got.push_back(sh);
				sda_oe_n_o <= rdm;
			end else if (bitn == 9) begin
				if (rdm && !adr)
					rdat = rdat + 8'h01;
				adr <= 1'b0;
				bitn <= 0;
				sda_oe_n_o <= !rdm || rdat[7];
			end else if (rdm && !adr)
				sda_oe_n_o <= rdat[7 - bitn];
		end
	end
endmodule // i2c_slave_model

// ==== i2c_master_engine_monitor.sv ====
`timescale 1ns/1ps
module i2c_master_engine_monitor (
	// Clock and reset
	input wire logic clock_i,
	input wire logic resetn_i,
	// Observed ports
	input wire logic spi_active_i,
	input wire logic cmd_valid_i,
	input wire logic cmd_taken_o,
	input wire logic int_clear_i,
	input wire logic int_n_o,
	input wire logic scl_i,
	input wire logic scl_oe_n_o,
	input wire logic sda_oe_n_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!resetn_i);

	sequence s_take;
		cmd_valid_i && cmd_taken_o;
	endsequence
	sequence s_spi_held;
		$past(spi_active_i) && $past(spi_active_i, 2);
	endsequence

	a_take_once: assert property (s_take |=> !cmd_taken_o [*2])
		else $error("command taken while busy");
	a_int_hold: assert property (!int_n_o && !int_clear_i |=> !int_n_o)
		else $error("interrupt left without clear");
	a_int_rise: assert property ($rose(int_n_o) |-> $past(int_clear_i))
		else $error("interrupt rose by itself");
	a_freeze_scl: assert property (s_spi_held |-> $stable(scl_oe_n_o))
		else $error("clock moved during command reception");
	a_scl_high_min: assert property ($rose(scl_oe_n_o) |-> scl_oe_n_o [*8])
		else $error("clock high phase too short");
	// An abort may release the clock early; it is followed by the completion interrupt
	a_scl_low_min: assert property ($fell(scl_oe_n_o) |-> (!scl_oe_n_o [*8]) or (##[1:10] $fell(int_n_o)))
		else $error("clock low phase too short");
	a_start_setup: assert property ($fell(sda_oe_n_o) && scl_i |-> scl_oe_n_o [*8])
		else $error("start without hold time");
	a_stop_idle: assert property ($rose(sda_oe_n_o) && scl_i |-> scl_oe_n_o [*8])
		else $error("clock driven after stop");
endmodule // i2c_master_engine_monitor

bind i2c_master_engine i2c_master_engine_monitor i2c_master_engine_monitor_i (
	.clock_i, .resetn_i, .spi_active_i, .cmd_valid_i, .cmd_taken_o,
	.int_clear_i, .int_n_o, .scl_i, .scl_oe_n_o, .sda_oe_n_o
);

// ==== i2c_master_engine_bench.sv ====
`timescale 1ns/1ps
module i2c_master_engine_bench;
	logic       clock_i = 1'b0;
	logic       resetn_i = 1'b0;
	logic [7:0] reg_addr_i = 8'h00;
	logic [7:0] reg_wdata_i = 8'h00;
	logic [7:0] cmd_count_i = 8'h00;
	logic [7:0] tx_data_i = 8'h00;
	logic [6:0] cmd_slave_i = 7'h50;
	logic       reg_wr_i = 1'b0;
	logic       reg_rd_i = 1'b0;
	logic       spi_active_i = 1'b0;
	logic       cmd_valid_i = 1'b0;
	logic       cmd_read_i = 1'b0;
	logic       tx_valid_i = 1'b0;
	logic       int_clear_i = 1'b0;
	logic       hold = 1'b0;
	logic       om_scl_oe_n = 1'b1;
	logic       om_sda_oe_n = 1'b1;
	logic [7:0] reg_rdata_o, rx_data_o;
	logic       cmd_taken_o, tx_ready_o, rx_valid_o, int_n_o, scl_oe_n_o, sda_oe_n_o;
	logic       slv_scl_oe_n, slv_sda_oe_n;
	logic [7:0] rxq[$];
	int         miscompares = 0;
	int         checked = 0;
	// Open-drain wires with pull-ups
	wire        scl = scl_oe_n_o & slv_scl_oe_n & om_scl_oe_n;
	wire        sda = sda_oe_n_o & slv_sda_oe_n & om_sda_oe_n;

	i2c_master_engine #(.TO_TICK_CYC_P(16), .SCL_LOW_CYC_P(200), .BUS_FREE_CYC_P(20)) i2c_master_engine_i (
		.clock_i, .resetn_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i, .reg_rdata_o,
		.spi_active_i, .cmd_valid_i, .cmd_read_i, .cmd_slave_i, .cmd_count_i, .cmd_taken_o,
		.tx_data_i, .tx_valid_i, .tx_ready_o, .rx_data_o, .rx_valid_o, .int_clear_i, .int_n_o,
		.scl_i(scl), .scl_o(), .scl_oe_n_o, .sda_i(sda), .sda_o(), .sda_oe_n_o
	);
	i2c_slave_model i2c_slave_model_i (.clock_i, .hold_i(hold), .scl_i(scl), .sda_i(sda),
		.scl_oe_n_o(slv_scl_oe_n), .sda_oe_n_o(slv_sda_oe_n));

	initial begin
		forever #10 clock_i = ~clock_i;
	end

	always @(posedge clock_i) begin
		if (rx_valid_o === 1'b1)
			rxq.push_back(rx_data_o);
	end

	task automatic wt(input int n);
		repeat (n) @(posedge clock_i);
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_i) begin
			reg_addr_i <= a;
			reg_wdata_i <= d;
			reg_wr_i <= 1'b1;
		end
		@(posedge clock_i) reg_wr_i <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clock_i) begin
			reg_addr_i <= a;
			reg_rd_i <= 1'b1;
		end
		@(posedge clock_i) reg_rd_i <= 1'b0;
		@(posedge clock_i) chk(reg_rdata_o, exp);
	endtask

	task automatic run(input logic r, input logic [7:0] n, input logic [7:0] st, output int c);
		@(posedge clock_i) begin
			cmd_read_i <= r;
			cmd_count_i <= n;
			cmd_valid_i <= 1'b1;
		end
		// Held past the take so that the repeats land on a busy engine
		wt(3);
		cmd_valid_i <= 1'b0;
		for (c = 0; c < 60000 && int_n_o !== 1'b0; c++)
			@(posedge clock_i);
		rd(8'h04, st);
		@(posedge clock_i) int_clear_i <= 1'b1;
		@(posedge clock_i) int_clear_i <= 1'b0;
	endtask

	task automatic om_bit(input logic b, output logic s);
		om_sda_oe_n <= b;
		wt(40);
		om_scl_oe_n <= 1'b1;
		wt(40);
		s = sda;
		om_scl_oe_n <= 1'b0;
		wt(40);
	endtask

	// Another master sends own address then one data byte
	task automatic om_frame(input logic [1:0] exp);
		logic [17:0] v;
		logic [1:0]  a;
		logic        s;
		int          i;
		v = {8'h42, 1'b1, 8'h5a, 1'b1};
		om_sda_oe_n <= 1'b0;
		wt(40);
		om_scl_oe_n <= 1'b0;
		for (i = 0; i < 18; i++) begin
			om_bit(v[17 - i], s);
			if (i == 8)
				a[1] = s;
			if (i == 17)
				a[0] = s;
		end
		om_sda_oe_n <= 1'b0;
		wt(40);
		om_scl_oe_n <= 1'b1;
		wt(40);
		om_sda_oe_n <= 1'b1;
		wt(40);
		chk({6'h00, a}, {6'h00, exp});
	endtask

	task automatic t_regs;
		rd(8'h02, 8'ha0);
		rd(8'h03, 8'h00);
		rd(8'h05, 8'h00);
		rd(8'h09, 8'h00);
		wr(8'h09, 8'hfc);
		rd(8'h09, 8'hfc);
		wr(8'h0a, 8'h55);
		rd(8'h0a, 8'h00);
		wr(8'h04, 8'h12);
		rd(8'h04, 8'h00);
		wr(8'h09, 8'h00);
		wr(8'h02, 8'h05);
		rd(8'h02, 8'h05);
		$display("test regs done");
	endtask

	task automatic t_write;
		int i;
		int c;
		@(posedge clock_i) tx_valid_i <= 1'b1;
		for (i = 0; i < 33; i++) begin
			tx_data_i <= 8'(i);
			@(posedge clock_i);
		end
		tx_valid_i <= 1'b0;
		@(posedge clock_i) chk({7'h00, tx_ready_o}, 8'h00);
		fork
			run(1'b0, 8'd33, 8'hf0, c);
			begin
				wt(1500);
				spi_active_i <= 1'b1;
				wt(400);
				spi_active_i <= 1'b0;
				wr(8'h02, 8'ha0);
			end
		join
		wr(8'h02, 8'h05);
		chk(8'(i2c_slave_model_i.got.size()), 8'd33);
		for (i = 0; i < 33; i++)
			chk(i2c_slave_model_i.got[i], 8'(i));
		$display("test write done");
	endtask

	task automatic t_read;
		int c;
		wr(8'h02, 8'h01);
		wr(8'h09, 8'h02);
		run(1'b1, 8'd3, 8'hf0, c);
		chk({7'h00, c >= 4500}, 8'h01);
		wr(8'h09, 8'h00);
		wr(8'h02, 8'h05);
		chk(8'(rxq.size()), 8'd3);
		for (c = 0; c < 3; c++)
			chk(rxq[c], 8'ha5 + 8'(c));
		$display("test read done");
	endtask

	task automatic t_nack;
		int c;
		om_sda_oe_n <= 1'b0;
		run(1'b0, 8'd0, 8'hfb, c);
		om_sda_oe_n <= 1'b1;
		cmd_slave_i <= 7'h33;
		run(1'b0, 8'd0, 8'hf1, c);
		wr(8'h03, 8'hff);
		run(1'b0, 8'd0, 8'hf8, c);
		chk({7'h00, c >= 2040 && c < 2400}, 8'h01);
		wr(8'h03, 8'h00);
		cmd_slave_i <= 7'h50;
		$display("test nack done");
	endtask

	task automatic t_slave;
		wr(8'h05, 8'h42);
		om_frame(2'b01);
		spi_active_i <= 1'b1;
		om_frame(2'b11);
		spi_active_i <= 1'b0;
		wr(8'h05, 8'h00);
		om_frame(2'b11);
		$display("test slave done");
	endtask

	task automatic t_low;
		int c;
		wr(8'h09, 8'h01);
		@(posedge clock_i) begin
			tx_data_i <= 8'h77;
			tx_valid_i <= 1'b1;
		end
		@(posedge clock_i) tx_valid_i <= 1'b0;
		fork
			run(1'b0, 8'd1, 8'hfa, c);
			begin
				wt(300);
				hold <= 1'b1;
			end
		join
		hold <= 1'b0;
		chk({7'h00, c < 800}, 8'h01);
		$display("test low done");
	endtask

	task automatic end_of_test;
		$display("counts: checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		wt(100000);
		miscompares++;
		end_of_test;
	end

	initial begin
		wt(8);
		resetn_i <= 1'b1;
		t_regs;
		t_write;
		t_read;
		t_nack;
		t_slave;
		t_low;
		end_of_test;
	end
endmodule // i2c_master_engine_bench
